// File: core/tpm_consts.svh
/*
  Register offsets, field positions, encodings and reset values of the timer channel block.
  Assumes it is included by the package and by the design file, each by its bare name.
*/
`ifndef TIMER_PWM_CONSTS_SVH
`define TIMER_PWM_CONSTS_SVH

// Structure.
`define NUM_CH        2
`define CNT_W         16
`define ADDR_W        8

// Byte offsets on the register bus, one 32-bit word per 8-bit register.
`define OFS_TSC       8'h00
`define OFS_CNT_HI    8'h04
`define OFS_CNT_LO    8'h08
`define OFS_MOD_HI    8'h0C
`define OFS_MOD_LO    8'h10
`define CH_BASE_HI    3'h1
`define CH_SEL_BIT    4
`define CH_REG_CS     2'h0
`define CH_REG_VH     2'h1
`define CH_REG_VL     2'h2

// Timer control/status fields.
`define TSC_FLAG      7
`define TSC_IE        6
`define TSC_CENTER    5
`define TSC_RUN       3

// Channel control/status fields.
`define CS_FLAG       7
`define CS_IE         6
`define CS_MSB        5
`define CS_MSA        4
`define CS_ELSB       3
`define CS_ELSA       2

// Values.
`define CNT_ZERO      16'h0000
`define CNT_ONE       16'h0001
`define CNT_MAX       16'hFFFF
`define SIGN_BIT      15
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY    1'b0
`define BYTE_ZERO     8'h00

`endif

// File: core/tpm_pkg.sv
/*
  Types of the timer channel block: bus carrier structs and the channel mode enumeration.
  Assumes tpm_consts.svh sits beside it in the include path.
*/
`include "tpm_consts.svh"

package timer_pwm_pkg;

  // Address and data phase signals that an AHB-Lite master drives into this slave.
  typedef struct packed {
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
  } ahb_req_s;

  // Slave answer.
  typedef struct packed {
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
  } ahb_rsp_s;

  // Effective behaviour of one channel.
  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM
  } ch_mode_e;

endpackage

// File: core/timer_pwm_channels.sv
/*
  Timer with a 16-bit up or up/down counter, modulus, overflow flag and NUM_CH channels
  offering input capture, output compare, edge-aligned and center-aligned PWM, reached
  over an AHB-Lite slave with 8-bit registers in the low byte of each word.
  Assumes channel pins are synchronous to sys_clk and a single master doing word transfers.
*/
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "tpm_consts.svh"

module timer_pwm_channels import timer_pwm_pkg::*; (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire ahb_req_s             ahbReq,
  input  wire logic                 hready,
  output      ahb_rsp_s             ahbRsp,
  input  wire logic [`NUM_CH-1:0]   chPinIn,
  output      logic [`NUM_CH-1:0]   chPinOut,
  output      logic [`NUM_CH-1:0]   chPinOe,
  output      logic                 overflowIrq,
  output      logic [`NUM_CH-1:0]   channelIrq
);

  // Bus data phase tracking; reads take one wait state so their side effects see settled state.
  logic                dValid_q;
  logic                dWrite_q;
  logic [`ADDR_W-1:0]  dAddr_q;
  logic                rdDone_q;
  logic [7:0]          hrdata_q;
  wire                 accept   = ahbReq.hsel && ahbReq.htrans == `HTRANS_NONSEQ && hready;
  wire                 readNow  = dValid_q && !dWrite_q && !rdDone_q;
  wire                 writeNow = dValid_q && dWrite_q;
  wire                 readyOut = !readNow;
  wire [7:0]           wByte    = ahbReq.hwdata[7:0];

  // Register select decode.
  wire                 selTsc   = dAddr_q == `OFS_TSC;
  wire                 selCntH  = dAddr_q == `OFS_CNT_HI;
  wire                 selCntL  = dAddr_q == `OFS_CNT_LO;
  wire                 selModH  = dAddr_q == `OFS_MOD_HI;
  wire                 selModL  = dAddr_q == `OFS_MOD_LO;
  wire                 selChAny = dAddr_q[7:5] == `CH_BASE_HI;
  wire [1:0]           chReg    = dAddr_q[3:2];

  // One driver for the whole answer struct: read byte, ready and an OKAY response.
  assign ahbRsp = {24'h000000, hrdata_q, readyOut, `HRESP_OKAY};

  // Address phase capture and the read wait state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dValid_q <= 1'b0;
      dWrite_q <= 1'b0;
      dAddr_q  <= '0;
      rdDone_q <= 1'b0;
    end else begin
      rdDone_q <= readNow;
      if (readyOut) begin
        dValid_q <= accept;
        dWrite_q <= ahbReq.hwrite;
        dAddr_q  <= ahbReq.haddr[`ADDR_W-1:0];
      end
    end
  end

  // Timer state.
  logic [`CNT_W-1:0]   cnt_q;
  logic                dirDown_q;
  logic [`CNT_W-1:0]   mod_q;
  logic [`CNT_W-1:0]   modBuf_q;
  logic                modHiW_q;
  logic                modLoW_q;
  logic                ovfFlag_q;
  logic                ovfArm_q;
  logic                ovfIe_q;
  logic                center_q;
  logic                run_q;
  logic                cntLatch_q;
  logic                cntHalfHi_q;
  logic [`CNT_W-1:0]   cntBuf_q;

  wire                 wrTsc   = writeNow && selTsc;
  wire                 wrCnt   = writeNow && (selCntH || selCntL);
  wire                 rdCnt   = readNow && (selCntH || selCntL);
  wire [`CNT_W-1:0]    termCnt = (mod_q == `CNT_ZERO) ? `CNT_MAX : mod_q;
  wire                 upWrap  = run_q && !center_q && cnt_q == termCnt;
  wire                 reverse = run_q && center_q && !dirDown_q && cnt_q == mod_q
                                 && mod_q != `CNT_ZERO;
  wire                 ovfEvent = upWrap || reverse;
  wire                 modApply = modHiW_q && modLoW_q && (!center_q || reverse);
  wire [`CNT_W-1:0]    cntView  = cntLatch_q ? cntBuf_q : cnt_q;

  // Up/down sequence; center select picks the counting mode.
  logic [`CNT_W-1:0]   cnt_d;
  logic                dirDown_d;
  always_comb begin
    cnt_d     = cnt_q;
    dirDown_d = dirDown_q;
    if (wrCnt) begin
      cnt_d     = `CNT_ZERO;
      dirDown_d = 1'b0;
    end else if (run_q && !center_q) begin
      cnt_d     = upWrap ? `CNT_ZERO : cnt_q + `CNT_ONE;
      dirDown_d = 1'b0;
    end else if (run_q && dirDown_q) begin
      cnt_d     = (cnt_q == `CNT_ZERO) ? `CNT_ONE : cnt_q - `CNT_ONE;
      dirDown_d = cnt_q != `CNT_ZERO;
    end else if (run_q) begin
      cnt_d     = reverse ? cnt_q - `CNT_ONE : cnt_q + `CNT_ONE;
      dirDown_d = reverse;
    end
  end

  // Counter, modulus buffer and timer control; a counter write also drops its read latch.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q       <= `CNT_ZERO;
      dirDown_q   <= 1'b0;
      mod_q       <= `CNT_ZERO;
      modBuf_q    <= `CNT_ZERO;
      modHiW_q    <= 1'b0;
      modLoW_q    <= 1'b0;
      ovfIe_q     <= 1'b0;
      center_q    <= 1'b0;
      run_q       <= 1'b0;
      cntLatch_q  <= 1'b0;
      cntHalfHi_q <= 1'b0;
      cntBuf_q    <= `CNT_ZERO;
    end else begin
      cnt_q     <= cnt_d;
      dirDown_q <= dirDown_d;
      if (modApply) begin
        mod_q    <= modBuf_q;
        modHiW_q <= 1'b0;
        modLoW_q <= 1'b0;
      end
      if (writeNow && selModH) begin
        modBuf_q[15:8] <= wByte;
        modHiW_q       <= 1'b1;
      end
      if (writeNow && selModL) begin
        modBuf_q[7:0] <= wByte;
        modLoW_q      <= 1'b1;
      end
      if (wrTsc) begin
        modHiW_q <= 1'b0;
        modLoW_q <= 1'b0;
        ovfIe_q  <= wByte[`TSC_IE];
        center_q <= wByte[`TSC_CENTER];
        run_q    <= wByte[`TSC_RUN];
      end
      if (wrCnt) begin
        cntLatch_q <= 1'b0;
      end else if (rdCnt && !cntLatch_q) begin
        cntLatch_q  <= 1'b1;
        cntHalfHi_q <= selCntH;
        cntBuf_q    <= cnt_q;
      end else if (rdCnt && cntHalfHi_q != selCntH) begin
        cntLatch_q <= 1'b0;
      end
    end
  end

  // Overflow flag two-step clear; a new event wins and restarts the sequence.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ovfFlag_q <= 1'b0;
      ovfArm_q  <= 1'b0;
    end else if (ovfEvent) begin
      ovfFlag_q <= 1'b1;
      ovfArm_q  <= 1'b0;
    end else if (wrTsc && !wByte[`TSC_FLAG] && ovfArm_q) begin
      ovfFlag_q <= 1'b0;
      ovfArm_q  <= 1'b0;
    end else if (readNow && selTsc && ovfFlag_q) begin
      ovfArm_q <= 1'b1;
    end
  end

  assign overflowIrq = ovfFlag_q && ovfIe_q;

  logic [7:0]          chCsRd  [`NUM_CH];
  logic [7:0]          chValRd [`NUM_CH];

  // Per-channel logic.
  for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
    logic              flag_q;
    logic              arm_q;
    logic              ie_q;
    logic              msb_q;
    logic              msa_q;
    logic              elsb_q;
    logic              elsa_q;
    logic [`CNT_W-1:0] val_q;
    logic [`CNT_W-1:0] buf_q;
    logic              hiW_q;
    logic              loW_q;
    logic              capLatch_q;
    logic              capHalfHi_q;
    logic [`CNT_W-1:0] capBuf_q;
    logic              pinPrev_q;
    logic              out_q;
    ch_mode_e          mode;

    wire sel    = selChAny && dAddr_q[`CH_SEL_BIT] == 1'(i);
    wire wrCs   = writeNow && sel && chReg == `CH_REG_CS;
    wire selVH  = sel && chReg == `CH_REG_VH;
    wire selVL  = sel && chReg == `CH_REG_VL;
    wire rdVal  = readNow && (selVH || selVL);

    // Center select overrides the mode bits, so edge PWM only up-counts.
    assign mode = center_q ? MODE_CENTER_PWM :
                  msb_q    ? MODE_EDGE_PWM   :
                  msa_q    ? MODE_COMPARE    : MODE_CAPTURE;

    wire isCap  = mode == MODE_CAPTURE;
    wire rise   = chPinIn[i] && !pinPrev_q;
    wire fall   = !chPinIn[i] && pinPrev_q;
    wire capEv  = isCap && ((elsa_q && rise) || (elsb_q && fall));
    wire match  = run_q && !isCap && cnt_q == val_q;
    wire both   = hiW_q && loW_q;
    // Zero wait; shared reversal; compare applies at once.
    wire xfer   = both && (mode == MODE_EDGE_PWM   ? cnt_q == `CNT_ZERO :
                           mode == MODE_CENTER_PWM ? reverse : 1'b1);
    wire [`CNT_W-1:0] effVal = xfer ? buf_q : val_q;
    // Sign and zero give 0%, above modulus gives 100%; the down-count match at
    // the value opens the pulse, so below the modulus the active span is exactly twice the value.
    wire cenActive = val_q != `CNT_ZERO && !val_q[`SIGN_BIT]
                     && (cnt_q < val_q || (cnt_q == val_q && dirDown_q));
    wire [`CNT_W-1:0] valView = capLatch_q ? capBuf_q : val_q;

    assign chCsRd[i]  = {flag_q, ie_q, msb_q, msa_q, elsb_q, elsa_q, 2'b00};
    assign chValRd[i] = selVH ? valView[15:8] : valView[7:0];
    assign channelIrq[i] = flag_q && ie_q;
    assign chPinOut[i]   = out_q;
    assign chPinOe[i]    = !isCap && (elsb_q || elsa_q);

    // Control, value and buffer registers.
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        ie_q        <= 1'b0;
        msb_q       <= 1'b0;
        msa_q       <= 1'b0;
        elsb_q      <= 1'b0;
        elsa_q      <= 1'b0;
        val_q       <= `CNT_ZERO;
        buf_q       <= `CNT_ZERO;
        hiW_q       <= 1'b0;
        loW_q       <= 1'b0;
        capLatch_q  <= 1'b0;
        capHalfHi_q <= 1'b0;
        capBuf_q    <= `CNT_ZERO;
        pinPrev_q   <= 1'b0;
      end else begin
        pinPrev_q <= chPinIn[i];
        if (capEv) begin
          val_q <= cnt_q;
        end else if (xfer) begin
          val_q <= buf_q;
        end
        if (xfer) begin
          hiW_q <= 1'b0;
          loW_q <= 1'b0;
        end
        if (writeNow && selVH) begin
          buf_q[15:8] <= wByte;
          hiW_q       <= 1'b1;
        end
        if (writeNow && selVL) begin
          buf_q[7:0] <= wByte;
          loW_q      <= 1'b1;
        end
        if (wrCs) begin
          capLatch_q <= 1'b0;
        end else if (rdVal && isCap && !capLatch_q) begin
          capLatch_q  <= 1'b1;
          capHalfHi_q <= selVH;
          capBuf_q    <= val_q;
        end else if (rdVal && capHalfHi_q != selVH) begin
          capLatch_q <= 1'b0;
        end
        if (wrCs) begin
          hiW_q  <= 1'b0;
          loW_q  <= 1'b0;
          ie_q   <= wByte[`CS_IE];
          msb_q  <= wByte[`CS_MSB];
          msa_q  <= wByte[`CS_MSA];
          elsb_q <= wByte[`CS_ELSB];
          elsa_q <= wByte[`CS_ELSA];
        end
      end
    end

    // Channel flag; a new event beats the clearing write.
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        flag_q <= 1'b0;
        arm_q  <= 1'b0;
      end else if (capEv || match) begin
        flag_q <= 1'b1;
        arm_q  <= 1'b0;
      end else if (wrCs && !wByte[`CS_FLAG] && arm_q) begin
        flag_q <= 1'b0;
        arm_q  <= 1'b0;
      end else if (readNow && sel && chReg == `CH_REG_CS && flag_q) begin
        arm_q <= 1'b1;
      end
    end

    // Pin drive per mode; the center output is evaluated every count so 0% and 100% hold.
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        out_q <= 1'b0;
      end else begin
        case (mode)
          MODE_COMPARE: begin
            if (match) begin
              out_q <= (elsb_q && elsa_q) ? 1'b1 :
                       elsb_q             ? 1'b0 :
                       elsa_q             ? !out_q : out_q;
            end
          end
          MODE_EDGE_PWM: begin
            // Overflow edge unless duty is zero, compare edge otherwise.
            if (run_q && cnt_q == `CNT_ZERO && effVal != `CNT_ZERO) begin
              out_q <= !elsa_q;
            end else if (match) begin
              out_q <= elsa_q;
            end
          end
          MODE_CENTER_PWM: begin
            // High around zero for select A low, inverted for high.
            if (run_q) begin
              out_q <= elsa_q ^ cenActive;
            end
          end
          default: begin
            out_q <= out_q;
          end
        endcase
      end
    end
  end

  // Read data selection.
  wire [7:0] chSelCs  = chCsRd[dAddr_q[`CH_SEL_BIT]];
  wire [7:0] chSelVal = chValRd[dAddr_q[`CH_SEL_BIT]];
  wire [7:0] tscRd    = {ovfFlag_q, ovfIe_q, center_q, 1'b0, run_q, 3'b000};
  wire [7:0] rdByte   = selTsc   ? tscRd :
                        selCntH  ? cntView[15:8] :
                        selCntL  ? cntView[7:0] :
                        selModH  ? mod_q[15:8] :
                        selModL  ? mod_q[7:0] :
                        (selChAny && chReg == `CH_REG_CS) ? chSelCs :
                        (selChAny && (chReg == `CH_REG_VH || chReg == `CH_REG_VL)) ? chSelVal :
                        `BYTE_ZERO;

  // Read data register, loaded in the wait cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hrdata_q <= `BYTE_ZERO;
    end else if (readNow) begin
      hrdata_q <= rdByte;
    end
  end

endmodule

// File: tb/timer_pwm_channels_chk.sv
/* Assertions on the bus, interrupt and pin-enable ports of the timer block.
   Assumes the type package is compiled first; attached to the design by the bind below. */
`timescale 1ns/1ps
`include "tpm_consts.svh"

module timer_pwm_channels_chk import timer_pwm_pkg::*; (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire ahb_req_s    ahbReq,
  input wire logic        hready,
  input wire ahb_rsp_s    ahbRsp,
  input wire logic [1:0]  chPinIn,
  input wire logic [1:0]  chPinOut,
  input wire logic [1:0]  chPinOe,
  input wire logic        overflowIrq,
  input wire logic [1:0]  channelIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Only a write data phase may change registers, so it gates register-driven changes.
  wire  taken = ahbReq.hsel && ahbReq.htrans == `HTRANS_NONSEQ && hready;
  logic wrPhase_q;
  always_ff @(posedge sys_clk) begin
    wrPhase_q <= rst_n && taken && ahbReq.hwrite;
  end

  // A read answers after exactly one wait cycle.
  sequence read_walk;
    !ahbRsp.hreadyout ##1 ahbRsp.hreadyout;
  endsequence
  sequence after_write;
    $past(wrPhase_q);
  endsequence

  read_wait_a: assert property (taken && !ahbReq.hwrite |=> read_walk)
    else $error("read wait not one cycle");
  write_fast_a: assert property (taken && ahbReq.hwrite |=> ahbRsp.hreadyout)
    else $error("write data phase stretched");
  resp_okay_a: assert property (ahbRsp.hresp == `HRESP_OKAY)
    else $error("error response seen");
  rdata_byte_a: assert property (ahbRsp.hreadyout |-> ahbRsp.hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  rdata_hold_a: assert property ($changed(ahbRsp.hrdata) |-> !$past(ahbRsp.hreadyout))
    else $error("read data moved outside a wait");
  ovf_irq_hold_a: assert property ($fell(overflowIrq) |-> after_write)
    else $error("overflow request dropped alone");
  ch_irq_hold_a: assert property (|($past(channelIrq) & ~channelIrq) |-> after_write)
    else $error("channel request dropped alone");
  oe_by_write_a: assert property ($changed(chPinOe) |-> after_write)
    else $error("pin enable moved without a write");
endmodule

bind timer_pwm_channels timer_pwm_channels_chk CHK (
  .sys_clk(sys_clk), .rst_n(rst_n), .ahbReq(ahbReq), .hready(hready),
  .ahbRsp(ahbRsp), .chPinIn(chPinIn), .chPinOut(chPinOut), .chPinOe(chPinOe),
  .overflowIrq(overflowIrq), .channelIrq(channelIrq));

// File: tb/pin_partner.sv
/* Event sources and loads on the channel pins.
   Assumes the design drives a pin only while its enable is high. */
`timescale 1ns/1ps
`include "tpm_consts.svh"

module pin_partner (
  input  wire logic [`NUM_CH-1:0] pinOut,
  input  wire logic [`NUM_CH-1:0] pinOe,
  input  wire logic               sys_clk,
  output wire logic [`NUM_CH-1:0] pinWire
);
  logic [`NUM_CH-1:0] levelQ = '0;

  // The source yields the pin to the device whenever the device enables its driver.
  assign pinWire = (pinOe & pinOut) | (~pinOe & levelQ);

  // One clean edge, launched just after a clock edge like a synchronous source.
  task automatic toggle(input int ch);
    @(posedge sys_clk);
    levelQ[ch] <= ~levelQ[ch];
  endtask

  // The load counts cycles seen high; a whole period makes the count phase-free.
  task automatic count_high(input int ch, input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (pinWire[ch] === 1'b1) k++;
    end
  endtask
endmodule

// File: tb/testbench.sv
/* Bench for the timer block: bus tasks, a pin partner and a duty model.
   Assumes the package, the checker and the partner are compiled ahead. */
`timescale 1ns/1ps
`include "tpm_consts.svh"

module testbench import timer_pwm_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  ahb_req_s    req = '0;
  ahb_rsp_s    rsp;
  wire  [1:0]  pinWire;
  logic [1:0]  pinOut;
  logic [1:0]  pinOe;
  logic        ovfIrq;
  logic [1:0]  chIrq;
  int          errCount = 0;
  int          checkCount = 0;
  int          cyc = 0;
  int          seed = 63233;
  wire  [3:0]  watch = {chIrq, ovfIrq, rsp.hreadyout};
  // Duty cases: four edge-aligned, then four centre-aligned.
  logic [7:0]  csT[8] = '{8'h28, 8'h24, 8'h28, 8'h28, 8'h08, 8'h04, 8'h08, 8'h08};
  logic [15:0] valT[8] = '{16'h0019, 16'h0019, 16'h0000, 16'h0070,
                           16'h0014, 16'h0014, 16'h8010, 16'h0040};

  // Clock and a cycle stamp used to time pin events.
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  timer_pwm_channels DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .ahbReq(req), .hready(rsp.hreadyout),
    .ahbRsp(rsp), .chPinIn(pinWire), .chPinOut(pinOut), .chPinOe(pinOe),
    .overflowIrq(ovfIrq), .channelIrq(chIrq));
  pin_partner PART (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .pinWire(pinWire));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bounded wait on one watched line; running out ends the run as a failure.
  task automatic wait_bit(input int b, input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (watch[b] !== 1'b1 && n < lim);
    if (watch[b] !== 1'b1) begin
      errCount++;
      report_and_stop();
    end
  endtask

  // One single transfer: address phase held until ready, then data phase until ready.
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    @(posedge sys_clk);
    req.hsel <= 1'b1;
    req.haddr <= {24'h000000, a};
    req.htrans <= `HTRANS_NONSEQ;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    wait_bit(0, 20, n);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= {24'h000000, wd};
    wait_bit(0, 20, n);
    rd = rsp.hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    bus(a, 1'b0, 8'h00, x);
    check({24'h000000, x}, {24'h000000, e});
  endtask

  // Expected high cycles in one period; the centre period is twice the modulus.
  function automatic int duty(input bit ctr, input logic [15:0] m, input logic a,
                              input logic [15:0] val);
    int hi;
    if (ctr) hi = (val == 16'h0000 || val[15]) ? 0 : (val > m) ? 2 * m : 2 * val;
    else hi = (val == 16'h0000) ? 0 : (val > m) ? m + 1 : val;
    return a ? (ctr ? 2 * m : m + 1) - hi : hi;
  endfunction

  // A hang is cut short here rather than left to the simulator.
  initial begin
    repeat (100000) @(posedge sys_clk);
    errCount++;
    report_and_stop();
  end

  initial begin
    logic [7:0]  h1, l1, h2, l2, pinOld;
    logic [15:0] v;
    int          t1, t2, k, n;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(`OFS_TSC, 8'h00);
    rdchk(8'hFC, 8'h00);
    wr(`OFS_TSC, 8'h08);
    wr(8'h20, 8'h4C);
    PART.toggle(0);
    t1 = cyc;
    repeat (3) @(posedge sys_clk);
    bus(8'h24, 1'b0, 8'h00, h1);
    repeat (60 + $unsigned($random(seed)) % 180) @(posedge sys_clk);
    PART.toggle(0);
    t2 = cyc;
    repeat (3) @(posedge sys_clk);
    bus(8'h28, 1'b0, 8'h00, l1);
    bus(8'h24, 1'b0, 8'h00, h2);
    bus(8'h28, 1'b0, 8'h00, l2);
    v = {h2, l2} - {h1, l1};
    check({16'h0000, v}, {16'h0000, 16'(t2 - t1)});
    check({31'h0, chIrq[0]}, 32'h1);
    rdchk(8'h20, 8'hCC);
    wr(8'h20, 8'h4C);
    repeat (2) @(posedge sys_clk);
    check({31'h0, chIrq[0]}, 32'h0);
    wr(8'h38, 8'h20);
    wr(8'h30, 8'h54);
    wr(8'h34, 8'h00);
    wr(8'h38, 8'h40);
    pinOld = {7'h00, pinOut[1]};
    wr(`OFS_CNT_HI, 8'h00);
    wait_bit(3, 200, n);
    check({31'h0, n > 48 && n < 80}, 32'h1);
    check({30'h0, pinOe[1], pinOut[1]}, {30'h0, 1'b1, ~pinOld[0]});
    for (int i = 0; i < 8; i++) begin
      v = i < 4 ? 16'h0063 : 16'h0032;
      wr(`OFS_TSC, i < 4 ? 8'h08 : 8'h28);
      wr(`OFS_MOD_HI, v[15:8]);
      wr(`OFS_MOD_LO, v[7:0]);
      wr(8'h30, csT[i]);
      wr(8'h34, valT[i][15:8]);
      wr(8'h38, valT[i][7:0]);
      repeat (300) @(posedge sys_clk);
      PART.count_high(1, 100, k);
      check(k, duty(i >= 4, v, csT[i][`CS_ELSA], valT[i]));
    end
    check({31'h0, pinOe[0]}, 32'h1);
    wr(`OFS_TSC, 8'h00);
    rdchk(`OFS_TSC, 8'h80);
    wr(`OFS_TSC, 8'h00);
    rdchk(`OFS_TSC, 8'h00);
    wr(`OFS_TSC, 8'h48);
    wait_bit(1, 300, n);
    wr(`OFS_TSC, 8'h40);
    rdchk(`OFS_TSC, 8'hC0);
    wr(`OFS_TSC, 8'h40);
    repeat (2) @(posedge sys_clk);
    check({31'h0, ovfIrq}, 32'h0);
    rdchk(`OFS_TSC, 8'h40);
    report_and_stop();
  end
endmodule
